// *** hdl/rsb_pkg.sv ***
// shared constants and types for the strap capture and boot select ends
`default_nettype none
package rsb_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned GROUP_WORDS = 4;
  localparam logic [1:0] BOOT_HOST_NOPLL = 2'h0;
  localparam logic [1:0] BOOT_I2C        = 2'h1;
  localparam logic [1:0] BOOT_HOST_PLL   = 2'h2;
  localparam logic [1:0] BOOT_RESERVED   = 2'h3;
  localparam logic [1:0] WORD_FIRST      = 2'h0;
  localparam logic [1:0] WORD_LAST       = 2'h3;
  localparam logic       WIDTH_16        = 1'h0;
  localparam logic       POL_LOW         = 1'h0;
  typedef enum logic [1:0] {RSB_BOOT_HOST, RSB_BOOT_I2C, RSB_BOOT_BAD} rsb_boot_t;
endpackage
`default_nettype wire

// *** hdl/rsb_link_if.sv ***
// host port link between the device end and the boot host end
`default_nettype none
interface rsb_link_if;
  logic [15:0] host_data_port;  // host to device data, bit 0 is lsb
  logic        host_strobe;     // data strobe, polarity per strap
  logic        host_ready;      // device status flag polled by host
  modport dev  (input host_data_port, input host_strobe, output host_ready);
  modport host (output host_data_port, output host_strobe, input host_ready);
endinterface
`default_nettype wire

// *** hdl/rsb_device.sv ***
// device end: strap capture at power-on reset release and boot selection
// Overview of operation
// - latch five straps at power-on release, hold
// - boot-source strap picks host, I2C or reserved
// - polarity strap 0 low strobes, 1 high
// - width strap 0 sixteen bits, 1 eight
// - PLL bypassed after power-on until software enables
// - start from internal ROM loader after reset
// - I2C mode only raises i2c_fetch; i2c_word and i2c_word_valid are not used
// - host boot polled, no DMA, device side
// - host polls status, no interrupts or DMA
// - host writes four words per group, eight on an 8-bit port, first most significant
// - strobe follows polarity strap latched; type strap latched, edge taken either way
// - hard reset keeps straps from last power-on
// - data bit 0 is least significant
// - hard reset driven only open-drain externally
`default_nettype none
module rsb_device (
  // clock and resets
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        power_on_reset_n,
  input  wire logic        hard_reset_in_n,
  output logic             hard_reset_out_n,
  output logic             hard_reset_oe_n,
  // straps
  input  wire logic [1:0]  boot_source_strap,
  input  wire logic        watchdog_enable_strap,
  input  wire logic        host_strobe_polarity_strap,
  input  wire logic        host_port_width_strap,
  input  wire logic        host_strobe_type_strap,
  // host port link
  rsb_link_if.dev          link,
  // boot side
  input  wire logic        pll_enable_sw,
  input  wire logic        i2c_word_valid,
  input  wire logic [15:0] i2c_word,
  output logic             pll_bypass,
  output logic             watchdog_en,
  output logic             rom_boot,
  output logic             i2c_fetch,
  output logic             boot_error,
  output logic [63:0]      boot_group,
  output logic             boot_group_valid,
  output logic             dma_en,
  output logic             irq_en
);
  logic [1:0]  boot_reg;
  logic        wdog_reg, pol_reg, width_reg, type_reg, straps_held_reg;
  logic        por_q_reg, strobe_q_reg, hard_q_reg;
  logic [1:0]  cnt_reg;
  logic        half_reg;
  logic [63:0] group_reg;

  // power-on release edge, straps captured on the first clock after it
  wire por_rise = power_on_reset_n & ~por_q_reg;
  wire in_reset = ~power_on_reset_n | ~hard_q_reg;
  rsb_pkg::rsb_boot_t mode;
  assign mode = (boot_reg == rsb_pkg::BOOT_I2C) ? rsb_pkg::RSB_BOOT_I2C :
                (boot_reg == rsb_pkg::BOOT_RESERVED) ? rsb_pkg::RSB_BOOT_BAD
                                                     : rsb_pkg::RSB_BOOT_HOST;
  // strobe normalised to active high; type strap latched but both settings take the rising edge
  wire strobe_act = (pol_reg == rsb_pkg::POL_LOW) ? ~link.host_strobe
                                                  : link.host_strobe;
  wire strobe_evt = type_reg ? (strobe_act & ~strobe_q_reg) : (strobe_act & ~strobe_q_reg);
  wire host_mode  = (mode == rsb_pkg::RSB_BOOT_HOST) & ~in_reset;
  wire take       = host_mode & strobe_evt;
  // bit 0 of the port is always the lsb; 8-bit mode uses low byte lane
  wire [15:0] din = (width_reg == rsb_pkg::WIDTH_16) ? link.host_data_port
                  : {8'h00, link.host_data_port[7:0]};
  wire word_done  = (width_reg == rsb_pkg::WIDTH_16) | half_reg;
  // one shifter feeds both the group and its hand-over, so byte mode keeps all eight bytes
  wire [63:0] next_group = (width_reg == rsb_pkg::WIDTH_16) ? {group_reg[47:0], din}
                         : {group_reg[55:0], din[7:0]};

  // strap capture, only power-on release and arst_n touch them so hard reset keeps them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      boot_reg <= 2'h0;
      wdog_reg <= 1'h0;
      pol_reg <= 1'h0;
      width_reg <= 1'h0;
      type_reg <= 1'h0;
      straps_held_reg <= 1'h0;
    end else if (por_rise) begin
      boot_reg <= boot_source_strap;
      wdog_reg <= watchdog_enable_strap;
      pol_reg <= host_strobe_polarity_strap;
      width_reg <= host_port_width_strap;
      type_reg <= host_strobe_type_strap;
      straps_held_reg <= 1'h1;
    end
  end

  // edge and level samplers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      por_q_reg <= 1'h0;
      strobe_q_reg <= 1'h0;
      hard_q_reg <= 1'h0;
    end else begin
      por_q_reg <= power_on_reset_n;
      strobe_q_reg <= strobe_act;
      hard_q_reg <= hard_reset_in_n;
    end
  end

  // group assembly, first word lands in the top slot
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= rsb_pkg::WORD_FIRST;
      half_reg <= 1'h0;
      group_reg <= 64'h0;
      boot_group_valid <= 1'h0;
      boot_group <= 64'h0;
    end else begin
      boot_group_valid <= 1'h0;
      if (in_reset) begin
        cnt_reg <= rsb_pkg::WORD_FIRST;
        half_reg <= 1'h0;
      end else if (take) begin
        half_reg <= ~word_done & ~half_reg;
        if (word_done) begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == rsb_pkg::WORD_LAST) begin
            boot_group <= next_group;
            boot_group_valid <= 1'h1;
          end
        end
        group_reg <= next_group;
      end
    end
  end

  // status and boot outputs, all registered
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pll_bypass <= 1'h1;
      watchdog_en <= 1'h0;
      rom_boot <= 1'h0;
      i2c_fetch <= 1'h0;
      boot_error <= 1'h0;
      link.host_ready <= 1'h0;
      dma_en <= 1'h0;
      irq_en <= 1'h0;
      hard_reset_out_n <= 1'h1;
      hard_reset_oe_n <= 1'h1;
    end else begin
      pll_bypass <= in_reset | (pll_bypass & ~pll_enable_sw);
      watchdog_en <= wdog_reg & ~in_reset;
      rom_boot <= straps_held_reg & ~in_reset;
      i2c_fetch <= (mode == rsb_pkg::RSB_BOOT_I2C) & ~in_reset & straps_held_reg;
      boot_error <= (mode == rsb_pkg::RSB_BOOT_BAD) & straps_held_reg;
      link.host_ready <= host_mode & straps_held_reg;
      dma_en <= 1'h0;
      irq_en <= 1'h0;
      hard_reset_out_n <= 1'h0;
      hard_reset_oe_n <= power_on_reset_n;                    // pull low during power-on
    end
  end
endmodule
`default_nettype wire

// *** hdl/rsb_host.sv ***
// boot host end: polls ready and writes 64-bit groups, first word most significant
`default_nettype none
module rsb_host (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // configuration, matching the straps
  input  wire logic        strobe_active_high,
  // host port link
  rsb_link_if.host         link,
  // user side
  input  wire logic        group_valid,
  input  wire logic [63:0] group_data,
  output logic             group_ready,
  output logic             hard_reset_out_n,
  output logic             hard_reset_oe_n
);
  typedef enum logic [1:0] {RSB_IDLE, RSB_DRIVE, RSB_STROBE, RSB_GAP} rsb_hstate_t;
  rsb_hstate_t state_reg;
  logic [1:0]  cnt_reg;
  logic [63:0] buf_reg;
  logic        strobe_reg;

  // most significant word first, bit 0 the lsb
  wire [15:0] cur_word = buf_reg[63:48];

  // strobe pin level from active flag and configured polarity
  assign link.host_strobe = strobe_reg ^ ~strobe_active_high;

  // transfer machine paced by polled ready, no interrupt use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= RSB_IDLE;
      cnt_reg <= rsb_pkg::WORD_FIRST;
      buf_reg <= 64'h0;
      strobe_reg <= 1'h0;
      group_ready <= 1'h0;
      link.host_data_port <= 16'h0;
      hard_reset_out_n <= 1'h0;
      hard_reset_oe_n <= 1'h1;
    end else begin
      group_ready <= 1'h0;
      hard_reset_out_n <= 1'h0;
      hard_reset_oe_n <= 1'h1;   // never drives high
      case (state_reg)
        RSB_IDLE: begin
          if (group_valid && link.host_ready && !group_ready) begin
            buf_reg <= group_data;
            cnt_reg <= rsb_pkg::WORD_FIRST;
            group_ready <= 1'h1;
            state_reg <= RSB_DRIVE;
          end
        end
        RSB_DRIVE: begin
          link.host_data_port <= cur_word;
          if (link.host_ready) begin
            state_reg <= RSB_STROBE;
          end
        end
        RSB_STROBE: begin
          strobe_reg <= 1'h1;
          state_reg <= RSB_GAP;
        end
        default: begin
          strobe_reg <= 1'h0;
          buf_reg <= {buf_reg[47:0], 16'h0};
          cnt_reg <= cnt_reg + 2'h1;
          state_reg <= (cnt_reg == rsb_pkg::WORD_LAST) ? RSB_IDLE : RSB_DRIVE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/rsb_properties.sv ***
// assertion checker for the strap capture and boot link
`default_nettype none
module rsb_properties (
  // clock and resets
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic power_on_reset_n,
  input wire logic hard_reset_n,
  // link
  input wire logic strobe_active_high,
  input wire logic host_strobe,
  input wire logic host_ready,
  // device status
  input wire logic i2c_fetch,
  input wire logic boot_error,
  input wire logic rom_boot,
  input wire logic pll_bypass,
  input wire logic watchdog_en,
  input wire logic dma_en,
  input wire logic irq_en,
  input wire logic boot_group_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // guarded by ready so a polarity change while idle is not judged
  sequence s_act;
    host_ready && host_strobe == strobe_active_high;
  endsequence
  sequence s_idle;
    host_strobe != strobe_active_high;
  endsequence
  a_no_dma_irq: assert property (!dma_en && !irq_en)
    else $error("dma or irq enabled");
  a_strobe_one: assert property (s_act |=> s_idle)
    else $error("strobe active over one cycle");
  a_ready_mode: assert property (host_ready |-> !i2c_fetch && !boot_error && rom_boot)
    else $error("ready outside host boot");
  a_i2c_rom: assert property (i2c_fetch |-> rom_boot && !host_ready)
    else $error("i2c fetch state wrong");
  a_bypass_por: assert property (!power_on_reset_n |=> pll_bypass)
    else $error("pll not bypassed after power-on");
  a_valid_pulse: assert property (boot_group_valid |=> !boot_group_valid)
    else $error("group valid too long");
  a_valid_ready: assert property (boot_group_valid |-> $past(host_ready))
    else $error("group outside host boot");
  // both resets must have been quiet long enough for the output stage to settle
  a_wd_hold: assert property ((power_on_reset_n && hard_reset_n) [*6] |-> $stable(watchdog_en))
    else $error("watchdog setting moved");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the strap capture and boot link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, arst_n, por_n, tb_hr, pol, spol, pll_sw, gv, wd, width;
  logic [1:0]  mode;
  logic [63:0] gd, bg;
  logic        d_oe, d_out, h_oe, h_out, hr_n, i2c_f, b_err, rom, byp, wde, dma, irq, bgv, g_rdy;
  int          n_errors, num_checks, cyc;
  rsb_link_if rsb_link_if_inst ();
  // open-drain hard reset wire, pulled up when nobody drives it
  assign hr_n = !((!d_oe && !d_out) || (!h_oe && !h_out) || tb_hr);
  rsb_device rsb_device_inst (.mclk(mclk), .arst_n(arst_n), .power_on_reset_n(por_n),
    .hard_reset_in_n(hr_n), .hard_reset_out_n(d_out), .hard_reset_oe_n(d_oe),
    .boot_source_strap(mode), .watchdog_enable_strap(wd), .host_strobe_polarity_strap(spol),
    .host_port_width_strap(width), .host_strobe_type_strap(spol), .link(rsb_link_if_inst),
    .pll_enable_sw(pll_sw), .i2c_word_valid(1'h0), .i2c_word(16'h0), .pll_bypass(byp),
    .watchdog_en(wde), .rom_boot(rom), .i2c_fetch(i2c_f), .boot_error(b_err),
    .boot_group(bg), .boot_group_valid(bgv), .dma_en(dma), .irq_en(irq));
  rsb_host rsb_host_inst (.mclk(mclk), .arst_n(arst_n), .strobe_active_high(pol),
    .link(rsb_link_if_inst), .group_valid(gv), .group_data(gd), .group_ready(g_rdy),
    .hard_reset_out_n(h_out), .hard_reset_oe_n(h_oe));
  rsb_properties rsb_properties_inst (.mclk(mclk), .arst_n(arst_n), .power_on_reset_n(por_n),
    .hard_reset_n(hr_n),
    .strobe_active_high(pol), .host_strobe(rsb_link_if_inst.host_strobe),
    .host_ready(rsb_link_if_inst.host_ready), .i2c_fetch(i2c_f), .boot_error(b_err),
    .rom_boot(rom), .pll_bypass(byp), .watchdog_en(wde), .dma_en(dma), .irq_en(irq),
    .boot_group_valid(bgv));
  // free-running 50 MHz clock
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hang is cut short well past the hundred and fifty or so cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t flag mismatch", $time);
    end
  endtask
  task automatic chk64(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t group %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // power-on boot; straps are flipped after capture to prove they are held
  task automatic t_boot(input logic [1:0] m, input logic w, input logic p, input logic b);
    por_n = 1'h0;
    cyc_n(2);
    mode = m; wd = w; pol = p; spol = p; width = b;
    cyc_n(2);
    por_n = 1'h1;
    cyc_n(2);
    mode = ~m; wd = ~w; spol = ~p; width = ~b;
    cyc_n(4);
    chk1(i2c_f, m == rsb_pkg::BOOT_I2C);
    chk1(b_err, m == rsb_pkg::BOOT_RESERVED);
    chk1(rsb_link_if_inst.host_ready, !m[0]);
    chk1(wde, w);
    chk1(byp, 1'h1);
    chk1(rom, 1'h1);
    $display("boot mode %0d done", m);
  endtask
  // one group of four words through the link, first word on top
  task automatic t_group(input logic [63:0] v);
    gd = v;
    gv = 1'h1;
    for (int i = 0; i < 20 && g_rdy !== 1'h1; i++) cyc_n(1);
    gv = 1'h0;
    for (int i = 0; i < 40 && bgv !== 1'h1; i++) cyc_n(1);
    chk1(bgv, 1'h1);
    chk64(bg, v);
    $display("group done");
  endtask
  // eight-bit port: device takes the low byte of each host word, eight takes per group
  task automatic t_byte(input logic [63:0] a, input logic [63:0] b);
    logic [63:0] e;
    e = {a[55:48], a[39:32], a[23:16], a[7:0], b[55:48], b[39:32], b[23:16], b[7:0]};
    t_boot(rsb_pkg::BOOT_HOST_NOPLL, 1'h0, 1'h0, 1'h1);
    for (int k = 0; k < 2; k++) begin
      gd = k ? b : a;
      gv = 1'h1;
      for (int i = 0; i < 20 && g_rdy !== 1'h1; i++) cyc_n(1);
      gv = 1'h0;
      for (int i = 0; i < 20 && (k == 0 || bgv !== 1'h1); i++) cyc_n(1);
    end
    chk1(bgv, 1'h1);
    chk64(bg, e);
    $display("byte group done");
  endtask
  // pll enable, then a hard reset that must keep the latched straps
  task automatic t_hard();
    pll_sw = 1'h1;
    cyc_n(1);
    pll_sw = 1'h0;
    cyc_n(2);
    chk1(byp, 1'h0);
    tb_hr = 1'h1;
    cyc_n(2);
    chk1(byp, 1'h1);
    tb_hr = 1'h0;
    cyc_n(3);
    chk1(wde, 1'h1);
    chk1(rsb_link_if_inst.host_ready, 1'h1);
    $display("hard reset done");
  endtask
  // main sequence
  initial begin
    arst_n = 1'h0; por_n = 1'h0; tb_hr = 1'h0; pol = 1'h0; spol = 1'h0; pll_sw = 1'h0;
    gv = 1'h0; gd = 64'h0; mode = 2'h0; wd = 1'h0; width = 1'h0;
    n_errors = 0; num_checks = 0; cyc = 0;
    cyc_n(4);
    arst_n = 1'h1;
    t_boot(2'h1, 1'h1, 1'h0, 1'h0);
    t_boot(2'h3, 1'h0, 1'h0, 1'h0);
    t_boot(2'h0, 1'h0, 1'h0, 1'h0);
    t_group(64'h0123_4567_89ab_cdef);
    t_boot(2'h2, 1'h1, 1'h1, 1'h0);
    t_group(64'hfedc_ba98_7654_3210);
    t_hard();
    t_group(64'h8000_0000_0000_0001);
    t_byte(64'h1101_2202_3303_4404, 64'h5505_6606_7707_8808);
    print_verdict();
  end
endmodule
`default_nettype wire
